// *** hw/clock_reset_generator.sv ***
// clock and reset generator: reset combining, pll modelling, clock selection,
// prescalers, sleep gating, pad clock gating and clock monitoring
// assumes oscillator and pad clocks are sampled as synchronous inputs to clk
//
// Operation
// - low reset pin raises external reset
// - power-on detector raises power reset
// - watchdog, remap or software request: system reset
// - power reset resets every register
// - system reset spares generator and remap registers
// - system clock from pll, external or rc oscillator
// - low-speed crystal feeds real-time clock
// - external clock from crystal or user clock
// - field selects pll input source
// - pll accepts 8 to 24 mhz input
// - pll out equals in times m/n/divider
// - fifteen clocks each pick pll, rc or external
// - four clocks divide by 1, 2, 4, 8
// - timer, pwm, watchdog divide up to 128
// - eight pwm and two timer clocks
// - random clock only from pll, undivided
// - converter and random clocks stop in sleep
// - network pad clocks gated by control
// - every generated clock selectable for monitoring
`timescale 1ns/1ps
module clock_reset_generator
	import clock_reset_pkg::*;
(
	// system clock and power-on detector (asynchronous, active low)
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// reset sources
	input  wire logic                          external_reset_pin_low,
	input  wire sys_rst_src_t                  sys_rst_src,
	// oscillator samples
	input  wire logic                          external_osc_clock,
	input  wire logic                          ext_osc_from_user,
	input  wire logic                          ext_user_clock,
	input  wire logic                          rc_osc_clock,
	input  wire logic                          rtc_crystal_clock,
	input  wire logic                          pll_vco_clock,
	// pll configuration
	input  wire pll_cfg_t                      pll_cfg,
	// per-clock source select and prescale
	input  wire logic [NUM_GEN*2-1:0]          src_sel,
	input  wire logic [4*PRE_SHORT_W-1:0]      pre_short,
	input  wire logic [11*PRE_LONG_W-1:0]      pre_long,
	// sleep, pad clocks and monitor
	input  wire logic                          cpu_sleep,
	input  wire logic                          net_receive_clock,
	input  wire logic                          net_transmit_clock,
	input  wire logic                          net_rx_gate_en,
	input  wire logic                          net_tx_gate_en,
	input  wire logic [MON_SEL_W-1:0]          monitor_sel,
	// generated resets
	output logic                               power_reset,
	output logic                               external_reset,
	output logic                               system_reset,
	output logic                               periph_rst_n,
	output logic                               gen_rst_n,
	// generated clocks
	output logic                               system_clock_out,
	output logic                               converter_clock,
	output logic                               sync_serial_clock,
	output logic                               serial_port_clock,
	output logic                               timer_clock_zero,
	output logic                               timer_clock_one,
	output logic [NUM_PWM-1:0]                 pwm_clock,
	output logic                               watchdog_clock_out,
	output logic                               random_gen_clock,
	output logic                               rtc_clock,
	output logic                               net_rx_clock_out,
	output logic                               net_tx_clock_out,
	output logic                               pll_output,
	output logic [PLL_FIELD_W+PLL_FIELD_W+OUT_DIV_W-1:0] pll_ratio,
	output logic                               monitor_clock
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// pick one of three sources
	function automatic logic pick(input logic [1:0] s, input logic p,
		input logic r, input logic e);
		logic v;
		v = p;
		case (s)
			SRC_RC:  v = r;
			SRC_EXT: v = e;
			default: v = p;
		endcase
		return v;
	endfunction

	// counter bit for a power-of-two divide; zero means pass through
	function automatic logic divtap(input logic [2:0] code, input logic src,
		input logic [DIV_CNT_W-1:0] cnt);
		logic v;
		v = (code == 3'h0) ? src : cnt[code - 3'h1];
		return v;
	endfunction

	// ------------------------------------------------------------------
	// reset combining
	// ------------------------------------------------------------------
	logic [RST_SYNC_STAGES-1:0] gen_sync_q;   // generator register reset release
	logic                       power_rst_q;  // power reset flag, held until release
	logic [RST_SYNC_STAGES-1:0] per_sync_q;   // peripheral reset release
	logic                       ext_rst_q;    // registered pin state
	logic                       sys_rst_q;    // registered system events
	wire                        sys_event = |sys_rst_src;
	wire                        per_rst_n = rst_n & ~external_reset_pin_low & ~sys_event;

	// power-on alone resets the generator's own registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gen_sync_q <= '0;
		end else begin
			gen_sync_q <= {gen_sync_q[RST_SYNC_STAGES-2:0], 1'b1};
		end
	end

	// power reset from its own flop so the output carries no gate;
	// it falls on the same edge at which the generator reset releases
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_rst_q <= 1'b1;
		end else begin
			power_rst_q <= ~gen_sync_q[RST_SYNC_STAGES-2];
		end
	end

	// pin and system events reset peripherals but not the generator
	always_ff @(posedge clk or negedge per_rst_n) begin
		if (!per_rst_n) begin
			per_sync_q <= '0;
		end else begin
			per_sync_q <= {per_sync_q[RST_SYNC_STAGES-2:0], 1'b1};
		end
	end

	// source flags, visible for status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_rst_q <= 1'b0;
			sys_rst_q <= 1'b0;
		end else begin
			ext_rst_q <= external_reset_pin_low;
			sys_rst_q <= sys_event;
		end
	end

	// ------------------------------------------------------------------
	// pll model: input select, bypass, ratio
	// ------------------------------------------------------------------
	// the analog loop itself lives outside; here the input choice and the
	// bypass path are built, and the ratio fields are held for the loop
	wire ext_osc   = ext_osc_from_user ? ext_user_clock : external_osc_clock;
	wire pll_in    = pll_cfg.ext_in_sel ? ext_osc : rc_osc_clock;
	wire pll_out_d = pll_cfg.bypass ? pll_in : pll_vco_clock;
	logic [PLL_FIELD_W+PLL_FIELD_W+OUT_DIV_W-1:0] ratio_q;   // m, n, divider for the loop
	logic                                    pll_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ratio_q <= {PLL_M_RST, PLL_N_RST, PLL_OUT_DIV_RST};
			pll_q   <= 1'b0;
		end else begin
			ratio_q <= {pll_cfg.mult, pll_cfg.div, pll_cfg.out_div};
			pll_q   <= pll_out_d;
		end
	end

	// ------------------------------------------------------------------
	// source selection and prescalers
	// ------------------------------------------------------------------
	// index order: sys, adc, ssp, uart, tim0, tim1, pwm0..7, wdog
	logic [NUM_GEN-1:0]   sel_clk;
	logic [NUM_GEN-1:0]   sel_prev_q;
	logic [DIV_CNT_W-1:0] cnt_q [NUM_GEN];
	logic [NUM_GEN-1:0]   div_clk;

	always_comb begin
		for (int i = 0; i < NUM_GEN; i++) begin
			sel_clk[i] = pick(src_sel[2*i +: 2], pll_out_d, rc_osc_clock, ext_osc);
		end
	end

	// each counter advances on a rising edge of its selected source
	always_ff @(posedge clk or negedge gen_sync_q[RST_SYNC_STAGES-1]) begin
		if (!gen_sync_q[RST_SYNC_STAGES-1]) begin
			sel_prev_q <= '0;
			for (int i = 0; i < NUM_GEN; i++) cnt_q[i] <= '0;
		end else begin
			sel_prev_q <= sel_clk;
			for (int i = 0; i < NUM_GEN; i++) begin
				if (sel_clk[i] && !sel_prev_q[i]) cnt_q[i] <= cnt_q[i] + 8'h01;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			div_clk[i] = divtap({1'b0, pre_short[PRE_SHORT_W*i +: PRE_SHORT_W]},
				sel_clk[i], cnt_q[i]);
		end
		for (int i = 4; i < NUM_GEN; i++) begin
			div_clk[i] = divtap(pre_long[PRE_LONG_W*(i-4) +: PRE_LONG_W],
				sel_clk[i], cnt_q[i]);
		end
	end

	// ------------------------------------------------------------------
	// gating and monitor
	// ------------------------------------------------------------------
	wire adc_d = div_clk[1] & ~cpu_sleep;
	wire rng_d = pll_out_d & ~cpu_sleep;
	wire rxc_d = net_receive_clock & net_rx_gate_en;
	wire txc_d = net_transmit_clock & net_tx_gate_en;
	logic [31:0] mon_vec;
	assign mon_vec = {12'h000, txc_d, rxc_d, rtc_crystal_clock, pll_out_d, rng_d,
		div_clk[14:2], adc_d, div_clk[0]};
	wire mon_d = mon_vec[monitor_sel];

	// all clock outputs registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			system_clock_out   <= 1'b0;
			converter_clock    <= 1'b0;
			sync_serial_clock  <= 1'b0;
			serial_port_clock  <= 1'b0;
			timer_clock_zero   <= 1'b0;
			timer_clock_one    <= 1'b0;
			pwm_clock          <= '0;
			watchdog_clock_out <= 1'b0;
			random_gen_clock   <= 1'b0;
			rtc_clock          <= 1'b0;
			net_rx_clock_out   <= 1'b0;
			net_tx_clock_out   <= 1'b0;
			monitor_clock      <= 1'b0;
		end else begin
			system_clock_out   <= div_clk[0];
			converter_clock    <= adc_d;
			sync_serial_clock  <= div_clk[2];
			serial_port_clock  <= div_clk[3];
			timer_clock_zero   <= div_clk[4];
			timer_clock_one    <= div_clk[5];
			pwm_clock          <= div_clk[13:6];
			watchdog_clock_out <= div_clk[14];
			random_gen_clock   <= rng_d;
			rtc_clock          <= rtc_crystal_clock;
			net_rx_clock_out   <= rxc_d;
			net_tx_clock_out   <= txc_d;
			monitor_clock      <= mon_d;
		end
	end

	// reset outputs, pll output and ratio
	assign power_reset    = power_rst_q;
	assign external_reset = ext_rst_q;
	assign system_reset   = sys_rst_q;
	assign periph_rst_n   = per_sync_q[RST_SYNC_STAGES-1];
	assign gen_rst_n      = gen_sync_q[RST_SYNC_STAGES-1];
	assign pll_output     = pll_q;
	assign pll_ratio      = ratio_q;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_ext_reset_flag: assert property (@(posedge clk) disable iff (!rst_n)
		external_reset_pin_low |=> external_reset)
		else $error("external reset not raised");
	a_sys_reset_flag: assert property (@(posedge clk) disable iff (!rst_n)
		sys_event |=> system_reset && !periph_rst_n)
		else $error("system reset not raised");
	a_gen_kept_sys: assert property (@(posedge clk) disable iff (!rst_n)
		gen_rst_n && sys_event |=> gen_rst_n)
		else $error("generator reset by system event");
	a_release_delay: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(periph_rst_n) |-> $past(per_rst_n, 2))
		else $error("peripheral reset released early");
	a_sleep_gates: assert property (@(posedge clk) disable iff (!rst_n)
		cpu_sleep |=> !converter_clock && !random_gen_clock)
		else $error("clock runs in sleep");
	a_net_gate: assert property (@(posedge clk) disable iff (!rst_n)
		!net_rx_gate_en && !net_tx_gate_en |=> !net_rx_clock_out && !net_tx_clock_out)
		else $error("pad clock not gated");
	a_bypass_path: assert property (@(posedge clk) disable iff (!rst_n)
		pll_cfg.bypass && !pll_cfg.ext_in_sel |=> pll_output == $past(rc_osc_clock))
		else $error("bypass path wrong");
	a_ratio_load: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> pll_ratio == $past({pll_cfg.mult, pll_cfg.div, pll_cfg.out_div}))
		else $error("pll ratio not loaded");
	a_rtc_follow: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> rtc_clock == $past(rtc_crystal_clock))
		else $error("rtc clock not forwarded");
	a_monitor_sys: assert property (@(posedge clk) disable iff (!rst_n)
		monitor_sel == 5'h00 |=> monitor_clock == system_clock_out)
		else $error("monitor does not follow system clock");
	a_rng_source: assert property (@(posedge clk) disable iff (!rst_n)
		!cpu_sleep |=> random_gen_clock == pll_output)
		else $error("random clock not taken from pll");

	c_sys_reset: cover property (@(posedge clk) disable iff (!rst_n) $rose(system_reset));
	c_sleep: cover property (@(posedge clk) disable iff (!rst_n) $rose(cpu_sleep));
	c_monitor: cover property (@(posedge clk) disable iff (!rst_n) $rose(monitor_clock));

endmodule

// *** hw/clock_reset_pkg.sv ***
// clock and reset generator: shared constants and carrier types
// assumes one system clock domain; all control bits arrive as plain ports
package clock_reset_pkg;

	// ------------------------------------------------------------------
	// clock source selection
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_PLL = 2'b00,   // pll output
		SRC_RC  = 2'b01,   // internal rc oscillator
		SRC_EXT = 2'b10    // external oscillator
	} src_sel_t;

	// ------------------------------------------------------------------
	// widths, reset values and timing
	// ------------------------------------------------------------------
	localparam int    PLL_FIELD_W     = 6;        // multiplier and divider width
	localparam int    OUT_DIV_W       = 2;        // output divider field width
	localparam int    PRE_SHORT_W     = 2;        // prescaler 1..8
	localparam int    PRE_LONG_W      = 3;        // prescaler 1..128
	localparam int    DIV_CNT_W       = 8;        // prescaler counter width
	localparam int    NUM_PWM         = 8;        // pwm channel clocks
	localparam int    NUM_GEN         = 15;       // generated clocks with select
	localparam int    MON_SEL_W       = 5;        // monitor select width
	localparam int    RST_SYNC_STAGES = 2;        // reset release stages
	localparam logic [PLL_FIELD_W-1:0] PLL_M_RST = 6'h01;
	localparam logic [PLL_FIELD_W-1:0] PLL_N_RST = 6'h01;
	localparam logic [OUT_DIV_W-1:0]   PLL_OUT_DIV_RST = 2'h0;
	localparam int    CLK_PERIOD_NS   = 5;        // system clock period

	// ------------------------------------------------------------------
	// packed carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic                   ext_in_sel;   // 1: external osc feeds pll
		logic                   bypass;       // pass pll input straight out
		logic [PLL_FIELD_W-1:0] mult;
		logic [PLL_FIELD_W-1:0] div;
		logic [OUT_DIV_W-1:0]   out_div;
	} pll_cfg_t;

	typedef struct packed {
		logic watchdog;
		logic remap_done;
		logic software;
	} sys_rst_src_t;

endpackage

// *** bench/clock_source_model.sv ***
// oscillator and pad clock model for the clock and reset generator
// assumes clk is the sampling clock; every output moves on its falling edge
`timescale 1ns/1ps
module clock_source_model (
	// sampling clock
	input  wire logic clk,
	// oscillator and pad clock samples
	output logic      rc_osc_clock,
	output logic      external_osc_clock,
	output logic      ext_user_clock,
	output logic      pll_vco_clock,
	output logic      rtc_crystal_clock,
	output logic      net_receive_clock,
	output logic      net_transmit_clock
);
	// ----------------------------------------------------------------
	// free-running phase counter
	// ----------------------------------------------------------------
	logic [6:0] cnt_q; // oscillators ignore chip reset, so no reset here
	initial cnt_q = 7'h00;
	// falling edge keeps the samples clear of the generator's sampling edge
	always @(negedge clk) begin
		cnt_q <= cnt_q + 7'h01;
	end
	// distinct oscillator periods let each oscillator be told apart by its edge rate; the pad clocks reuse two of them
	assign rc_osc_clock       = cnt_q[1]; // period 4
	assign external_osc_clock = cnt_q[2]; // period 8
	assign ext_user_clock     = cnt_q[3]; // period 16
	assign pll_vco_clock      = cnt_q[4]; // period 32
	assign rtc_crystal_clock  = cnt_q[5]; // period 64
	assign net_receive_clock  = cnt_q[3]; // period 16
	assign net_transmit_clock = cnt_q[2]; // period 8
endmodule

// *** bench/clock_reset_generator_test.sv ***
// self-checking bench for the clock and reset generator
// assumes the source model's periods; rates are counted over fixed windows
`timescale 1ns/1ps
module clock_reset_generator_test
	import clock_reset_pkg::*;
;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic                clk, rst_n, external_reset_pin_low, ext_osc_from_user;
	logic                cpu_sleep, net_rx_gate_en, net_tx_gate_en;
	logic                rc_osc_clock, external_osc_clock, ext_user_clock, pll_vco_clock;
	logic                rtc_crystal_clock, net_receive_clock, net_transmit_clock;
	sys_rst_src_t        sys_rst_src;
	pll_cfg_t            pll_cfg;
	logic [29:0]         src_sel;
	logic [7:0]          pre_short;
	logic [32:0]         pre_long;
	logic [4:0]          monitor_sel;
	logic                power_reset, external_reset, system_reset, periph_rst_n, gen_rst_n;
	logic                system_clock_out, converter_clock, sync_serial_clock;
	logic                serial_port_clock, timer_clock_zero, timer_clock_one;
	logic                watchdog_clock_out, random_gen_clock, rtc_clock, pll_output;
	logic                net_rx_clock_out, net_tx_clock_out, monitor_clock;
	logic [7:0]          pwm_clock;
	logic [13:0]         pll_ratio;
	logic [20:0]         obs;         // every clock, indexed as the monitor codes
	int                  num_errors, comparisons;
	localparam logic [13:0] RATIO = {6'h2A, 6'h05, 2'h3};
	localparam int          FULL  = 192;  // rc rises in one window

	assign obs = {monitor_clock, net_tx_clock_out, net_rx_clock_out, rtc_clock, pll_output,
		random_gen_clock, watchdog_clock_out, pwm_clock, timer_clock_one, timer_clock_zero,
		serial_port_clock, sync_serial_clock, converter_clock, system_clock_out};

	clock_reset_generator dut (.clk, .rst_n, .external_reset_pin_low, .sys_rst_src,
		.external_osc_clock, .ext_osc_from_user, .ext_user_clock, .rc_osc_clock,
		.rtc_crystal_clock, .pll_vco_clock, .pll_cfg, .src_sel, .pre_short, .pre_long,
		.cpu_sleep, .net_receive_clock, .net_transmit_clock, .net_rx_gate_en,
		.net_tx_gate_en, .monitor_sel, .power_reset, .external_reset, .system_reset,
		.periph_rst_n, .gen_rst_n, .system_clock_out, .converter_clock, .sync_serial_clock,
		.serial_port_clock, .timer_clock_zero, .timer_clock_one, .pwm_clock,
		.watchdog_clock_out, .random_gen_clock, .rtc_clock, .net_rx_clock_out,
		.net_tx_clock_out, .pll_output, .pll_ratio, .monitor_clock);

	clock_source_model sources (.clk, .rc_osc_clock, .external_osc_clock, .ext_user_clock,
		.pll_vco_clock, .rtc_crystal_clock, .net_receive_clock, .net_transmit_clock);

	// ----------------------------------------------------------------
	// clock and shared checks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
	end

	task automatic check_vec(input logic [13:0] got, input logic [13:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// rise count over a window; one edge of slack for prescaler phase
	task automatic check_rate(input int idx, input int exp);
		int   n;
		logic p;
		n = 0;
		repeat (8) @(negedge clk);
		p = obs[idx];
		repeat (768) begin
			@(negedge clk);
			if (p === 1'b0 && obs[idx] === 1'b1)
				n++;
			p = obs[idx];
		end
		comparisons++;
		if (n < exp - 1 || n > exp + 1) begin
			num_errors++;
			$display("wrong value at %0t: clock %0d rose %0d, expected %0d", $time, idx, n, exp);
		end
	endtask

	task automatic defaults;
		src_sel = {15{2'b01}};
		pre_short = 8'h00;
		pre_long = 33'h0;
		pll_cfg = {1'b0, 1'b1, RATIO};
		cpu_sleep = 1'b0;
		ext_osc_from_user = 1'b0;
	endtask

	task automatic results;
		$display("comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		repeat (20) @(negedge clk);
		check_vec(power_reset, 1'b1);
		check_vec(pll_ratio, {PLL_M_RST, PLL_N_RST, PLL_OUT_DIV_RST});
		rst_n = 1'b1;
		@(negedge clk);
		check_vec(gen_rst_n, 1'b0);
		check_vec(power_reset, 1'b1);
		@(negedge clk);
		check_vec(gen_rst_n, 1'b1);
		check_vec(power_reset, 1'b0);
		check_vec(pll_ratio, RATIO);
		$display("reset test done");
	endtask

	// three system events then the pin, each released and recovered
	task automatic t_sources;
		for (int i = 0; i < 4; i++) begin
			if (i == 3)
				external_reset_pin_low = 1'b1;
			else
				sys_rst_src = sys_rst_src_t'(3'h1 << i);
			repeat (2) @(negedge clk);
			check_vec(periph_rst_n, 1'b0);
			if (i == 3)
				check_vec(external_reset, 1'b1);
			else begin
				check_vec(system_reset, 1'b1);
				check_vec(gen_rst_n, 1'b1);
				check_vec(pll_ratio, RATIO);
			end
			sys_rst_src = 3'h0;
			external_reset_pin_low = 1'b0;
			repeat (4) @(negedge clk);
			check_vec(periph_rst_n, 1'b1);
		end
		$display("reset source test done");
	endtask

	task automatic t_pll;
		pll_cfg.bypass = 1'b0;
		check_rate(16, 24);
		pll_cfg.bypass = 1'b1;
		check_rate(16, FULL);
		pll_cfg.ext_in_sel = 1'b1;
		check_rate(16, 96);
		ext_osc_from_user = 1'b1;
		check_rate(16, 48);
		defaults();
		$display("pll test done");
	endtask

	// system and serial port clocks on different sources at once
	task automatic t_select;
		int rate [3];
		rate = '{24, FULL, 96};
		pll_cfg.bypass = 1'b0;
		for (int c = 0; c < 3; c++) begin
			src_sel[1:0] = 2'(c);
			src_sel[7:6] = 2'((c + 1) % 3);
			check_rate(0, rate[c]);
			check_rate(3, rate[(c + 1) % 3]);
		end
		defaults();
		$display("select test done");
	endtask

	task automatic t_prescale;
		for (int k = 0; k < 4; k++) begin
			pre_short = {4{2'(k)}};
			check_rate(k, FULL >> k);
		end
		for (int k = 0; k < 8; k++) begin
			pre_long = {11{3'(k)}};
			check_rate(4 + k % 2, FULL >> k);
			check_rate(6 + k, FULL >> k);
		end
		check_rate(14, 1);
		defaults();
		$display("prescale test done");
	endtask

	// random clock ignores prescalers; sleep stops only converter and random
	task automatic t_sleep;
		pre_short = 8'hFF;
		check_rate(15, FULL);
		pre_short = 8'h00;
		pll_cfg.bypass = 1'b0;
		check_rate(15, 24);
		cpu_sleep = 1'b1;
		check_rate(1, 0);
		check_rate(15, 0);
		check_rate(0, FULL);
		cpu_sleep = 1'b0;
		check_rate(1, FULL);
		defaults();
		$display("sleep test done");
	endtask

	task automatic t_pads;
		net_rx_gate_en = 1'b0;
		net_tx_gate_en = 1'b0;
		check_rate(18, 0);
		check_rate(19, 0);
		net_rx_gate_en = 1'b1;
		net_tx_gate_en = 1'b1;
		check_rate(18, 48);
		check_rate(19, 96);
		check_rate(17, 12);
		$display("pad clock test done");
	endtask

	task automatic t_monitor;
		int code [8];
		int rate [8];
		code = '{0, 1, 14, 15, 16, 17, 18, 19};
		rate = '{FULL, FULL, FULL, FULL, FULL, 12, 48, 96};
		for (int i = 0; i < 8; i++) begin
			monitor_sel = 5'(code[i]);
			check_rate(20, rate[i]);
		end
		$display("monitor test done");
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		num_errors = 0;
		comparisons = 0;
		rst_n = 1'b0;
		external_reset_pin_low = 1'b0;
		sys_rst_src = 3'h0;
		net_rx_gate_en = 1'b1;
		net_tx_gate_en = 1'b1;
		monitor_sel = 5'h00;
		defaults();
		t_reset();
		t_sources();
		t_pll();
		t_select();
		t_prescale();
		t_sleep();
		t_pads();
		t_monitor();
		results();
	end

	// about 40000 cycles are expected; a hang ends the run as a failure
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		results();
	end
endmodule
